// *** hw/counter_array_top.sv ***
// Counter array with two 16-bit PWM modules and a watchdog on the counter high byte.
// Assumes an AXI4-Lite master on aclk and an idle indication from the processor on aclk.
//
// Summary of operation
// - Output high on match, low on overflow.
// - Wide PWM needs three enable bits set.
// - Match sets module flag when enabled.
// - Counter overflow sets the overflow flag.
// - Low byte write clears, high sets enable.
// - Duty equals 65536 minus compare, over 65536.
// - Comparator disabled holds the output low.
// - Watchdog fires on low wrap with match.
// - Timeout is 256 reload plus remainder.
// - Writing force flag resets while enabled.
// - High byte write restarts the watchdog.
// - Clock and idle select frozen while enabled.
// - Enable bit or lock bit enables watchdog.
// - Lock holds watchdog on until reset.
// - Reset: watchdog on, divide 12, zeros.
// - Idle suspend halts watchdog in idle.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module counter_array_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Processor state and device outputs.
  input wire logic idle_mode,
  output logic [1:0] module_output_pin,
  output logic watchdog_reset
);
  import counter_array_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic [15:0] count; // Shared counter.
  logic [3:0] prescale; // Counter clock divider.
  logic step; // Counter took a new value last edge.
  logic ovf_flag; // Counter overflow flag.
  logic run_bit; // Software run control.
  logic [1:0] match_flag; // Per-module match flags.
  logic idle_sus; // Suspend counting in idle.
  logic wd_en; // Watchdog enable bit.
  logic wd_lock; // Watchdog lock bit.
  logic [1:0] clk_sel; // Counter clock select.
  logic [1:0][7:0] cfg; // Module configuration.
  logic [1:0][15:0] cmp; // Module compare values.
  logic [7:0] wd_reload; // Watchdog reload byte.
  logic [7:0] wd_offset; // Watchdog offset byte.
  logic [1:0] pwm_match; // Match pulses from the modules.
  logic [31:0] rd_data; // Read mux output.

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A write is taken when address and data are both offered and no response waits.
  wire wr_go = awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  wire lo_we = wstrb[0];
  wire hi_we = wstrb[1];
  wire wr_ctrl = wr_go & (awaddr == OFF_CTRL);
  wire wr_mode = wr_go & (awaddr == OFF_MODE);
  wire wr_wd = wr_go & (awaddr == OFF_WDCMP);
  wire [1:0] wr_cfg = {wr_go & (awaddr == OFF_CFG1), wr_go & (awaddr == OFF_CFG0)};
  wire [1:0] wr_cmp = {wr_go & (awaddr == OFF_CMP1), wr_go & (awaddr == OFF_CMP0)};
  wire wr_hit = wr_ctrl | wr_mode | wr_wd | (|wr_cfg) | (|wr_cmp) | (awaddr == OFF_COUNT);
  // A read is taken when an address is offered and no read data waits.
  wire rd_go = arvalid & ~rvalid;
  assign arready = rd_go;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter clock and counter.

  wire wd_on = wd_en | wd_lock;
  // Divide count for the selected counter clock.
  wire [3:0] div_max = (clk_sel == SEL_SYS) ? DIV_ONE :
                       (clk_sel == SEL_DIV4) ? DIV_MID : DIV_SLOW;
  wire pre_done = (prescale >= div_max - 4'h1);
  // Counting stops in idle when suspend is chosen, which also holds the watchdog.
  wire cnt_go = (run_bit | wd_on) & ~(idle_sus & idle_mode);
  wire tick = cnt_go & pre_done;

  // Divider produces one tick per counter clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 4'h0;
    end else if (!cnt_go || pre_done) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  // Counter steps once per tick; the low byte carries into the high byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
      step <= 1'b0;
    end else begin
      step <= tick;
      if (tick) begin
        count <= count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PWM modules.

  for (genvar i = 0; i < 2; i++) begin : g_pwm
    pwm_compare_unit u_unit (
      .aclk(aclk),
      .aresetn(aresetn),
      .step(step),
      .count(count),
      .compare(cmp[i]),
      .cmp_en(cfg[i][CFG_CMPEN_BIT]),
      .pwm_en(cfg[i][CFG_PWM_BIT]),
      .wide_sel(cfg[i][CFG_WIDE_BIT]),
      .pin(module_output_pin[i]),
      .match(pwm_match[i])
    );
  end

  // Configuration and compare storage; byte writes steer the comparator enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= {2{CFG_RESET}};
      cmp <= {2{CMP_RESET}};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_cfg[i] && lo_we) begin
          cfg[i] <= wdata[7:0];
        end
        if (wr_cmp[i] && lo_we) begin
          cmp[i][7:0] <= wdata[7:0];
          cfg[i][CFG_CMPEN_BIT] <= 1'b0;
        end
        if (wr_cmp[i] && hi_we) begin
          cmp[i][15:8] <= wdata[15:8];
          cfg[i][CFG_CMPEN_BIT] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control flags; a hardware set wins over a software clear in the same cycle.

  wire ovf_set = tick & (count == 16'hffff);
  wire [1:0] flag_set = {pwm_match[1] & cfg[1][CFG_MATEN_BIT],
                         pwm_match[0] & cfg[0][CFG_MATEN_BIT]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag <= 1'b0;
      run_bit <= 1'b0;
      match_flag <= 2'h0;
    end else begin
      if (wr_ctrl && lo_we) begin
        run_bit <= wdata[CTRL_RUN_BIT];
      end
      if (ovf_set) begin
        ovf_flag <= 1'b1;
      end else if (wr_ctrl && lo_we) begin
        ovf_flag <= wdata[CTRL_OVF_BIT];
      end
      for (int i = 0; i < 2; i++) begin
        if (flag_set[i]) begin
          match_flag[i] <= 1'b1;
        end else if (wr_ctrl && lo_we) begin
          match_flag[i] <= wdata[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog.

  // Mode writes; select fields are frozen while the watchdog runs, lock is sticky.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_en <= MODE_RESET[MODE_WDEN_BIT];
      wd_lock <= MODE_RESET[MODE_LOCK_BIT];
      idle_sus <= MODE_RESET[MODE_IDLE_BIT];
      clk_sel <= MODE_RESET[MODE_SEL_LSB +: 2];
    end else if (wr_mode && lo_we) begin
      wd_en <= wdata[MODE_WDEN_BIT];
      wd_lock <= wd_lock | wdata[MODE_LOCK_BIT];
      if (!wd_on) begin
        idle_sus <= wdata[MODE_IDLE_BIT];
        clk_sel <= wdata[MODE_SEL_LSB +: 2];
      end
    end
  end

  // The new reload byte is used when both bytes arrive in one write.
  wire [7:0] reload_eff = lo_we ? wdata[7:0] : wd_reload;
  wire [7:0] next_offset = count[15:8] + reload_eff;
  // Restart: offset becomes the high counter byte plus the reload count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_reload <= WD_RESET;
      wd_offset <= WD_RESET;
    end else if (wr_wd) begin
      if (lo_we) begin
        wd_reload <= wdata[7:0];
      end
      if (hi_we) begin
        wd_offset <= next_offset;
      end
    end
  end

  // Expiry on a low byte wrap while the high byte equals the offset, or a forced one.
  wire wd_expire = tick & wd_on & (count[7:0] == 8'hff) & (count[15:8] == wd_offset);
  wire wd_force = wr_ctrl & lo_we & wdata[CTRL_FORCE_BIT] & wd_on;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wd_expire | wd_force;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus responses.

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (araddr)
      OFF_CTRL: rd_data = {24'h000000, ovf_flag, run_bit, 4'h0, match_flag};
      OFF_MODE: rd_data = {24'h000000, idle_sus, wd_en, wd_lock, 2'h0, clk_sel, 1'b0};
      OFF_COUNT: rd_data = {16'h0000, count};
      OFF_CFG0: rd_data = {24'h000000, cfg[0]};
      OFF_CMP0: rd_data = {16'h0000, cmp[0]};
      OFF_CFG1: rd_data = {24'h000000, cfg[1]};
      OFF_CMP1: rd_data = {16'h0000, cmp[1]};
      OFF_WDCMP: rd_data = {16'h0000, wd_offset, wd_reload};
      default: rd_data = 32'h0000_0000;
    endcase
  end
  wire rd_hit = (araddr == OFF_CTRL) | (araddr == OFF_MODE) | (araddr == OFF_COUNT) |
                (araddr == OFF_CFG0) | (araddr == OFF_CMP0) | (araddr == OFF_CFG1) |
                (araddr == OFF_CMP1) | (araddr == OFF_WDCMP);

  // Read data stands until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Write response stands until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_wd_expire: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_expire |=> watchdog_reset) else $error("watchdog expiry gave no reset");
  a_wd_force: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_force |=> watchdog_reset) else $error("forced watchdog gave no reset");
  a_wd_quiet_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !wd_on |=> !watchdog_reset) else $error("reset while watchdog disabled");
  a_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_lock |=> wd_lock && wd_on) else $error("locked watchdog turned off");
  a_select_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_on |=> $stable(clk_sel) && $stable(idle_sus)) else $error("select changed");
  a_idle_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_sus && idle_mode) |=> $stable(count)) else $error("counted in idle");
  a_ovf_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_set |=> ovf_flag) else $error("overflow flag not set");
  a_match_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_set[0] |=> match_flag[0]) else $error("match flag not set");
  a_low_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_cmp[0] && lo_we && !hi_we) |=> !cfg[0][CFG_CMPEN_BIT])
    else $error("low byte write left comparator on");
  a_restart_offset: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_wd && hi_we) |=> wd_offset == $past(next_offset)) else $error("bad offset");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> count == $past(count) + 16'h0001) else $error("counter did not step");
  c_wd_expire: cover property (@(posedge aclk) disable iff (!aresetn) wd_expire);
  c_wd_force: cover property (@(posedge aclk) disable iff (!aresetn) wd_force);
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) ovf_set);
  c_pwm_flag: cover property (@(posedge aclk) disable iff (!aresetn) flag_set[1]);
endmodule : counter_array_top
`default_nettype wire

// *** shared/counter_array_pkg.sv ***
// Constants for the counter array: register offsets, field positions, reset values
// and clock divide counts.
// Assumes an AXI4-Lite slave with 32-bit data and an 8-bit byte address.
package counter_array_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CFG0 = 8'h10;
  localparam logic [7:0] OFF_CMP0 = 8'h14;
  localparam logic [7:0] OFF_CFG1 = 8'h18;
  localparam logic [7:0] OFF_CMP1 = 8'h1c;
  localparam logic [7:0] OFF_WDCMP = 8'h20;
  // Control register fields.
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_FORCE_BIT = 2;
  // Mode register fields.
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_WDEN_BIT = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_SEL_LSB = 1;
  // Module configuration fields.
  localparam int CFG_WIDE_BIT = 7;
  localparam int CFG_CMPEN_BIT = 6;
  localparam int CFG_MATEN_BIT = 3;
  localparam int CFG_PWM_BIT = 1;
  localparam int CFG_IRQEN_BIT = 0;
  // Reset values.
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [7:0] WD_RESET = 8'h00;
  // Counter clock select codes and divide counts.
  localparam logic [1:0] SEL_DIV12 = 2'h0;
  localparam logic [1:0] SEL_DIV4 = 2'h1;
  localparam logic [1:0] SEL_SYS = 2'h2;
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_MID = 4'h4;
  localparam logic [3:0] DIV_ONE = 4'h1;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : counter_array_pkg

// *** hw/pwm_compare_unit.sv ***
// One 16-bit PWM compare module of the counter array.
// Assumes count is the shared counter and step is high the cycle after it moved.
`timescale 1ns/1ps
`default_nettype none
module pwm_compare_unit (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Shared counter.
  input wire logic step,
  input wire logic [15:0] count,
  // Module settings.
  input wire logic [15:0] compare,
  input wire logic cmp_en,
  input wire logic pwm_en,
  input wire logic wide_sel,
  // Results.
  output logic pin,
  output logic match
);
  // The module is in 16-bit PWM only with all three bits set.
  wire active = cmp_en & pwm_en & wide_sel;
  // A fresh counter value equal to the compare value is a match.
  assign match = step & active & (count == compare);
  // Counter just wrapped to zero.
  wire wrap = step & (count == 16'h0000);

  // Output: high on match, low on wrap; match wins so a compare of zero stays high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin <= 1'b0;
    end else if (!active) begin
      pin <= 1'b0;
    end else if (match) begin
      pin <= 1'b1;
    end else if (wrap) begin
      pin <= 1'b0;
    end
  end

  a_pin_rise_match: assert property (@(posedge aclk) disable iff (!aresetn)
    match |=> pin) else $error("pwm output not high after match");
  a_pin_fall_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (wrap && compare != 16'h0000) |=> !pin) else $error("pwm output not low after wrap");
  a_pin_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !active |=> !pin) else $error("pwm output high while not enabled");
  c_pin_rises: cover property (@(posedge aclk) disable iff (!aresetn) !pin ##1 pin);
endmodule : pwm_compare_unit
`default_nettype wire

// *** tb/tb_counter_array_top.sv ***
// Self-checking bench for counter_array_top: wide PWM, watchdog and register behaviour.
// Assumes the package from shared/ and the design from hw/; one clock, no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_counter_array_top;
  import counter_array_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Signals driven by the bench start at known values at time zero.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, idle_mode = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, watchdog_reset;
  logic [1:0] bresp, rresp, module_output_pin;
  logic [31:0] rdata, rd;
  logic [1:0] rsp;
  int fails = 0;
  int n_checks = 0;
  int pulses = 0;
  always #4 aclk = ~aclk;
  // Counts every watchdog reset pulse, so short pulses are never missed.
  always @(posedge aclk) if (watchdog_reset === 1'b1) pulses <= pulses + 1;
  counter_array_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .idle_mode(idle_mode), .module_output_pin(module_output_pin),
    .watchdog_reset(watchdog_reset));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and compare tasks.
  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task automatic check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check_resp
  // Cycle counts may differ from the ideal by up to tol cycles of tick alignment.
  task automatic check_near(input string nm, input int e, input int g, input int tol);
    n_checks++;
    if (g < e - tol || g > e + tol) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_near
  task automatic timeout(input string nm);
    fails++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    print_verdict();
  endtask : timeout
  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master: address and data offered together, held until taken.
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready === 1'b1 && wready === 1'b1) break;
    end
    if (i == 50) timeout("write_take");
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (i = 0; i < 50; i++) begin
      if (bvalid === 1'b1) break;
      @(posedge aclk);
    end
    if (i == 50) timeout("write_resp");
    r = bresp;
    bready <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    if (i == 50) timeout("read_take");
    arvalid <= 1'b0;
    for (i = 0; i < 50; i++) begin
      if (rvalid === 1'b1) break;
      @(posedge aclk);
    end
    if (i == 50) timeout("read_resp");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : bus_read
  // Mapped accesses must always answer OKAY.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bus_write(a, d, s, rsp);
    check_resp("bresp", RESP_OKAY, rsp);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    bus_read(a, rd, rsp);
    check_resp("rresp", RESP_OKAY, rsp);
  endtask : rdr
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // Counts cycles until the watchdog pulse is seen.
  task automatic wait_wd(input int lim, output int n);
    n = 0;
    while (watchdog_reset !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > lim) timeout("watchdog_wait");
    end
    // One more edge so the pulse counter has taken this pulse before a caller reads it.
    @(posedge aclk);
  endtask : wait_wd
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_default;
    int n;
    do_reset();
    wait_wd(4000, n);
    check_near("wd_default_cycles", 256 * int'(DIV_SLOW), n, 13);
    $display("test default timeout done");
  endtask : t_default
  task automatic t_pwm;
    int i, n;
    logic p1, p0;
    p1 = 1'b0;
    p0 = 1'b0;
    wr(OFF_MODE, 32'h00, 4'h1);
    wr(OFF_MODE, 32'h04, 4'h1);
    wr(OFF_CTRL, 32'h40, 4'h1);
    wr(OFF_CFG1, 32'h4a, 4'h1);
    wr(OFF_CMP1, 32'hff00, 4'h3);
    wr(OFF_CFG0, 32'hcb, 4'h1);
    wr(OFF_CMP0, 32'h00, 4'h1);
    rdr(OFF_CFG0);
    check_val("cfg0_after_low", 32'h8b, rd);
    wr(OFF_CMP0, 32'hff00, 4'h2);
    rdr(OFF_CFG0);
    check_val("cfg0_after_high", 32'hcb, rd);
    wr(OFF_CTRL, 32'h40, 4'h1);
    for (i = 0; i < 70000; i++) begin
      @(posedge aclk);
      if (module_output_pin[1] !== 1'b0) p1 = 1'b1;
      if (module_output_pin[0] === 1'b1) break;
    end
    if (i == 70000) timeout("pwm_rise");
    check_val("pin1_not_wide", 32'h0, {31'h0, p1});
    for (n = 0; module_output_pin[0] === 1'b1; n++) begin
      @(posedge aclk);
      if (n > 1000) timeout("pwm_fall");
    end
    check_near("pwm_high_cycles", 65536 - 32'hff00, n, 0);
    rdr(OFF_CTRL);
    check_val("ctrl_flags", 32'h81, rd & 32'h81);
    // Just after the wrap a small compare value gives a match within a few dozen cycles.
    wr(OFF_CMP0, 32'h40, 4'h1);
    wr(OFF_CMP0, 32'h00, 4'h2);
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (module_output_pin[0] === 1'b1) break;
    end
    if (i == 200) timeout("pwm_rise_short");
    // With the output high, a low byte write must drop it at once.
    wr(OFF_CMP0, 32'h40, 4'h1);
    repeat (20) begin
      @(posedge aclk);
      if (module_output_pin[0] !== 1'b0) p0 = 1'b1;
    end
    check_val("pin0_disabled", 32'h0, {31'h0, p0});
    $display("test wide pwm done");
  endtask : t_pwm
  task automatic t_idle;
    logic [31:0] c;
    int n;
    wr(OFF_MODE, 32'h84, 4'h1);
    wr(OFF_WDCMP, 32'h02, 4'h1);
    idle_mode <= 1'b1;
    wr(OFF_MODE, 32'hc4, 4'h1);
    rdr(OFF_COUNT);
    c = rd;
    repeat (5) @(posedge aclk);
    rdr(OFF_COUNT);
    check_val("count_frozen", c, rd);
    wr(OFF_MODE, 32'h40, 4'h1);
    rdr(OFF_MODE);
    check_val("mode_locked_fields", 32'hc4, rd);
    wr(OFF_WDCMP, 32'h0, 4'h2);
    rdr(OFF_WDCMP);
    check_val("wd_offset", {16'h0, c[15:8] + 8'h02, 8'h02}, rd);
    idle_mode <= 1'b0;
    wait_wd(1000, n);
    check_near("wd_restart_cycles", 512 + 256 - int'(c[7:0]), n, 3);
    $display("test idle and restart done");
  endtask : t_idle
  task automatic t_force;
    int p;
    p = pulses;
    wr(OFF_CTRL, 32'h44, 4'h1);
    repeat (2) @(posedge aclk);
    check_val("force_pulse", p + 1, pulses);
    wr(OFF_MODE, 32'h00, 4'h1);
    p = pulses;
    wr(OFF_CTRL, 32'h44, 4'h1);
    repeat (2) @(posedge aclk);
    check_val("force_disabled", p, pulses);
    $display("test force done");
  endtask : t_force
  task automatic t_lock;
    int p;
    wr(OFF_MODE, 32'h20, 4'h1);
    p = pulses;
    wr(OFF_CTRL, 32'h44, 4'h1);
    repeat (2) @(posedge aclk);
    check_val("lock_enables", p + 1, pulses);
    wr(OFF_MODE, 32'h00, 4'h1);
    rdr(OFF_MODE);
    check_val("lock_sticky", 32'h20, rd);
    p = pulses;
    wr(OFF_CTRL, 32'h44, 4'h1);
    repeat (2) @(posedge aclk);
    check_val("lock_still_on", p + 1, pulses);
    $display("test lock done");
  endtask : t_lock
  task automatic t_regs;
    do_reset();
    rdr(OFF_MODE);
    check_val("mode_reset", {24'h0, MODE_RESET}, rd);
    rdr(OFF_COUNT);
    check_val("count_reset", 32'h0, rd);
    rdr(OFF_WDCMP);
    check_val("wdcmp_reset", {24'h0, WD_RESET}, rd);
    rdr(OFF_CFG0);
    check_val("cfg0_reset", {24'h0, CFG_RESET}, rd);
    rdr(OFF_CMP0);
    check_val("cmp0_reset", {16'h0, CMP_RESET}, rd);
    bus_read(8'h0c, rd, rsp);
    check_resp("unmapped_rresp", RESP_SLVERR, rsp);
    check_val("unmapped_rdata", 32'h0, rd);
    bus_write(8'h3c, 32'hff, 4'hf, rsp);
    check_resp("unmapped_bresp", RESP_SLVERR, rsp);
    $display("test registers done");
  endtask : t_regs
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    t_default();
    t_pwm();
    t_idle();
    t_force();
    t_lock();
    t_regs();
    print_verdict();
  end
endmodule : tb_counter_array_top
`default_nettype wire
